/* shared/berrx_bus_if.sv */
`timescale 1ns/10ps
interface berrx_bus_if;
  logic [13:0] addr;
  logic [15:0] wdata;
  logic wr_strobe;
  logic rd_strobe;
  logic [15:0] rdata;

  modport dev (
    input addr,
    input wdata,
    input wr_strobe,
    input rd_strobe,
    output rdata
  );

  modport host (
    output addr,
    output wdata,
    output wr_strobe,
    output rd_strobe,
    input rdata
  );
endinterface : berrx_bus_if

/* shared/berrx_consts.svh */
`ifndef BERRX_CONSTS_SVH
`define BERRX_CONSTS_SVH

// register space offsets (word addresses, address bit 13 low)
`define BERRX_OFS_CTRL 13'h0000
`define BERRX_OFS_START 13'h0300
`define BERRX_OFS_LENGTH 13'h0320
`define BERRX_OFS_ERROR 13'h0360

// address fields
`define BERRX_A_MEMSPACE 13
`define BERRX_A_STREAM_HI 12
`define BERRX_A_STREAM_LO 8
`define BERRX_A_CHAN_HI 7
`define BERRX_A_CHAN_LO 0

// field positions
`define BERRX_START_HI 7
`define BERRX_LENGTH_HI 8
`define BERRX_MEMSEL_HI 1

// reset values
`define BERRX_RST_CTRL 2'h0
`define BERRX_RST_START 8'h00
`define BERRX_RST_LENGTH 9'h000
`define BERRX_RST_ERROR 16'h0000
`define BERRX_ERR_MAX 16'hFFFF

// host controller's own register offsets
`define BERRX_HOST_ADDR 3'h0
`define BERRX_HOST_WDATA 3'h1
`define BERRX_HOST_CMD 3'h2
`define BERRX_HOST_RDATA 3'h3
`define BERRX_HOST_STATUS 3'h4

`endif

/* shared/berrx_pkg.sv */
package berrx_pkg;

  // memory selected by the control register for address bit 13 high accesses
  typedef enum logic [1:0] {
    BERRX_MEM_DATA = 2'h0,
    BERRX_MEM_CM_LOW = 2'h1,
    BERRX_MEM_CM_HIGH = 2'h2
  } berrx_memsel_t;

  // per-stream data rate
  typedef enum logic [1:0] {
    BERRX_RATE_2M = 2'h0,
    BERRX_RATE_4M = 2'h1,
    BERRX_RATE_8M = 2'h2,
    BERRX_RATE_16M = 2'h3
  } berrx_rate_t;

  typedef enum logic [1:0] {
    BERRX_H_IDLE,
    BERRX_H_STROBE,
    BERRX_H_CAPTURE
  } berrx_hstate_t;

  typedef struct packed {
    logic [1:0] mem_sel;
    logic [15:0][7:0] start;
    logic [15:0][8:0] len;
    logic [15:0][15:0] err;
    logic [15:0] rdata;
    logic [15:0] cm_low_q;
    logic [15:0] cm_high_q;
  } berrx_dev_state_t;

  typedef struct packed {
    berrx_hstate_t state;
    logic is_read;
    logic done;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [13:0] bus_addr;
    logic [15:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [15:0] cpu_rdata;
  } berrx_host_state_t;

endpackage : berrx_pkg

/* src/berrx_dev.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "berrx_consts.svh"

module berrx_dev
  import berrx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  berrx_bus_if.dev bus,
  input wire logic [15:0] err_event,
  input wire logic [15:0] rx_restart,
  input wire logic [15:0][1:0] stream_rate,
  input wire logic dm_wr,
  input wire logic [11:0] dm_addr,
  input wire logic [15:0] dm_wdata,
  input wire logic [11:0] cm_rd_addr,
  output logic [15:0][7:0] start_channel,
  output logic [15:0][8:0] rx_length,
  output logic [15:0][15:0] error_count,
  output logic [1:0] mem_select,
  output logic [15:0] cm_low_q,
  output logic [15:0] cm_high_q
);

  berrx_dev_state_t s_reg;
  berrx_dev_state_t s_next;

  // 16 streams x 256 channels each; no reset, contents are traffic not control
  logic [15:0] data_mem [0:4095];
  logic [15:0] cm_low_mem [0:4095];
  logic [15:0] cm_high_mem [0:4095];

  logic mem_space;
  logic [4:0] stream_sel;
  logic [7:0] chan_sel;
  logic [3:0] reg_idx;
  logic [12:0] reg_base;
  logic chan_ok;
  logic mem_hit;
  logic [11:0] mem_idx;
  logic [15:0] mem_rd_word;
  logic [15:0] reg_rd_word;
  logic [15:0][15:0] err_next;
  logic stream_ok;
  logic ctrl_hit;
  logic start_hit;
  logic len_hit;
  logic err_hit;
  logic reg_wr;
  logic mem_wr;
  wire logic [15:0] err_full;
  logic [15:0] host_rd_word;

  assign mem_space = bus.addr[`BERRX_A_MEMSPACE];
  assign stream_sel = bus.addr[`BERRX_A_STREAM_HI:`BERRX_A_STREAM_LO];
  assign chan_sel = bus.addr[`BERRX_A_CHAN_HI:`BERRX_A_CHAN_LO];
  assign reg_idx = bus.addr[3:0];
  assign reg_base = {bus.addr[12:4], 4'h0};

  // register decode is gated by address bit 13 so memory addresses never alias a register
  assign ctrl_hit = !mem_space && (bus.addr[12:0] == `BERRX_OFS_CTRL);
  assign start_hit = !mem_space && (reg_base == `BERRX_OFS_START);
  assign len_hit = !mem_space && (reg_base == `BERRX_OFS_LENGTH);
  assign err_hit = !mem_space && (reg_base == `BERRX_OFS_ERROR);
  assign reg_wr = bus.wr_strobe && !mem_space;

  // channels above the stream's rate are not backed: writes dropped, reads zero
  always_comb begin
    case (berrx_rate_t'(stream_rate[stream_sel[3:0]]))
      BERRX_RATE_2M: chan_ok = (chan_sel[7:5] == 3'h0);
      BERRX_RATE_4M: chan_ok = (chan_sel[7:6] == 2'h0);
      BERRX_RATE_8M: chan_ok = (chan_sel[7] == 1'b0);
      BERRX_RATE_16M: chan_ok = 1'b1;
      default: chan_ok = 1'b0;
    endcase
  end

  // stream numbers 16-31 are outside the sixteen streams
  assign stream_ok = !stream_sel[4];
  assign mem_hit = mem_space && stream_ok && chan_ok;
  assign mem_idx = {stream_sel[3:0], chan_sel};
  assign mem_wr = bus.wr_strobe && mem_hit;

  // data memory is filled by the switch only; host writes there are dropped
  always_ff @(posedge ref_clk) begin
    if (dm_wr) begin
      data_mem[dm_addr] <= dm_wdata;
    end
  end

  // one write port per array keeps each a plain RAM
  always_ff @(posedge ref_clk) begin
    if (mem_wr && s_reg.mem_sel == BERRX_MEM_CM_LOW) begin
      cm_low_mem[mem_idx] <= bus.wdata;
    end
    if (mem_wr && s_reg.mem_sel == BERRX_MEM_CM_HIGH) begin
      cm_high_mem[mem_idx] <= bus.wdata;
    end
  end

  always_comb begin
    case (berrx_memsel_t'(s_reg.mem_sel))
      BERRX_MEM_DATA: mem_rd_word = data_mem[mem_idx];
      BERRX_MEM_CM_LOW: mem_rd_word = cm_low_mem[mem_idx];
      BERRX_MEM_CM_HIGH: mem_rd_word = cm_high_mem[mem_idx];
      default: mem_rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    reg_rd_word = 16'h0000;
    if (ctrl_hit) begin
      reg_rd_word = {14'h0000, s_reg.mem_sel};
    end else if (start_hit) begin
      reg_rd_word = {8'h00, s_reg.start[reg_idx]};
    end else if (len_hit) begin
      reg_rd_word = {7'h00, s_reg.len[reg_idx]};
    end else if (err_hit) begin
      reg_rd_word = s_reg.err[reg_idx];
    end
  end

  always_comb begin
    if (!mem_space) begin
      host_rd_word = reg_rd_word;
    end else if (mem_hit) begin
      host_rd_word = mem_rd_word;
    end else begin
      // out-of-rate channels and streams above 15 read as zero
      host_rd_word = 16'h0000;
    end
  end

  // an error in the restart cycle is kept: it counts as the first of the new run
  generate
    for (genvar i = 0; i < 16; i++) begin : g_err
      assign err_full[i] = (s_reg.err[i] == `BERRX_ERR_MAX);
      always_comb begin
        if (rx_restart[i]) begin
          err_next[i] = {15'h0000, err_event[i]};
        end else if (err_event[i] && !err_full[i]) begin
          err_next[i] = s_reg.err[i] + 16'h0001;
        end else begin
          err_next[i] = s_reg.err[i];
        end
      end
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    s_next.err = err_next;
    // rdata is zero outside the answer cycle
    s_next.rdata = 16'h0000;
    s_next.cm_low_q = cm_low_mem[cm_rd_addr];
    s_next.cm_high_q = cm_high_mem[cm_rd_addr];
    if (reg_wr) begin
      if (ctrl_hit) begin
        s_next.mem_sel = bus.wdata[`BERRX_MEMSEL_HI:0];
      end else if (start_hit) begin
        // upper byte is not stored, so it can never read back nonzero
        s_next.start[reg_idx] = bus.wdata[`BERRX_START_HI:0];
      end else if (len_hit) begin
        s_next.len[reg_idx] = bus.wdata[`BERRX_LENGTH_HI:0];
      end
      // error counters take no host write
    end
    if (bus.rd_strobe) begin
      s_next.rdata = host_rd_word;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg.mem_sel <= `BERRX_RST_CTRL;
      s_reg.start <= {16{`BERRX_RST_START}};
      s_reg.len <= {16{`BERRX_RST_LENGTH}};
      s_reg.err <= {16{`BERRX_RST_ERROR}};
      s_reg.rdata <= 16'h0000;
      s_reg.cm_low_q <= 16'h0000;
      s_reg.cm_high_q <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.rdata = s_reg.rdata;
  assign start_channel = s_reg.start;
  assign rx_length = s_reg.len;
  assign error_count = s_reg.err;
  assign mem_select = s_reg.mem_sel;
  assign cm_low_q = s_reg.cm_low_q;
  assign cm_high_q = s_reg.cm_high_q;

endmodule : berrx_dev

/* src/berrx_host.sv */
`timescale 1ns/10ps
`include "berrx_consts.svh"

module berrx_host
  import berrx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  berrx_bus_if.host bus,
  input wire logic [2:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [15:0] cpu_rdata
);

  berrx_host_state_t s_reg;
  berrx_host_state_t s_next;
  logic [12:0] tgt_base;
  logic [15:0] wdata_clean;

  assign tgt_base = {s_reg.addr[12:4], 4'h0};

  // reserved upper bits of start and length writes are forced to zero so software slips never reach the device
  always_comb begin
    wdata_clean = s_reg.wdata;
    if (!s_reg.addr[`BERRX_A_MEMSPACE] && tgt_base == `BERRX_OFS_START) begin
      wdata_clean = {8'h00, s_reg.wdata[`BERRX_START_HI:0]};
    end else if (!s_reg.addr[`BERRX_A_MEMSPACE] && tgt_base == `BERRX_OFS_LENGTH) begin
      wdata_clean = {7'h00, s_reg.wdata[`BERRX_LENGTH_HI:0]};
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.cpu_rdata = 16'h0000;
    s_next.bus_wr = 1'b0;
    s_next.bus_rd = 1'b0;
    if (cpu_wr && cpu_addr == `BERRX_HOST_ADDR) begin
      s_next.addr = cpu_wdata[13:0];
    end
    if (cpu_wr && cpu_addr == `BERRX_HOST_WDATA) begin
      s_next.wdata = cpu_wdata;
    end
    case (s_reg.state)
      BERRX_H_IDLE: begin
        // a command while busy is ignored; status shows busy
        if (cpu_wr && cpu_addr == `BERRX_HOST_CMD && (cpu_wdata[0] || cpu_wdata[1])) begin
          s_next.state = BERRX_H_STROBE;
          s_next.done = 1'b0;
          s_next.is_read = cpu_wdata[1] && !cpu_wdata[0];
          s_next.bus_addr = s_reg.addr;
          s_next.bus_wdata = wdata_clean;
          s_next.bus_wr = cpu_wdata[0];
          s_next.bus_rd = cpu_wdata[1] && !cpu_wdata[0];
        end
      end
      BERRX_H_STROBE: begin
        if (s_reg.is_read) begin
          s_next.state = BERRX_H_CAPTURE;
        end else begin
          s_next.state = BERRX_H_IDLE;
          s_next.done = 1'b1;
        end
      end
      BERRX_H_CAPTURE: begin
        s_next.rdata = bus.rdata;
        s_next.done = 1'b1;
        s_next.state = BERRX_H_IDLE;
      end
      default: begin
        s_next.state = BERRX_H_IDLE;
      end
    endcase
    if (cpu_rd) begin
      case (cpu_addr)
        `BERRX_HOST_ADDR: s_next.cpu_rdata = {2'h0, s_reg.addr};
        `BERRX_HOST_WDATA: s_next.cpu_rdata = s_reg.wdata;
        `BERRX_HOST_RDATA: s_next.cpu_rdata = s_reg.rdata;
        `BERRX_HOST_STATUS: s_next.cpu_rdata = {14'h0000, s_reg.done, s_reg.state != BERRX_H_IDLE};
        default: s_next.cpu_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.addr = s_reg.bus_addr;
  assign bus.wdata = s_reg.bus_wdata;
  assign bus.wr_strobe = s_reg.bus_wr;
  assign bus.rd_strobe = s_reg.bus_rd;
  assign cpu_rdata = s_reg.cpu_rdata;

endmodule : berrx_host

/* test/ber_receiver_regs_memory_map_tb.sv */
`timescale 1ns/10ps
`include "berrx_consts.svh"
module ber_receiver_regs_memory_map_tb;
  logic ref_clk, rstn, cpu_wr, cpu_rd, dm_wr;
  logic [2:0] cpu_addr;
  logic [15:0] cpu_wdata, cpu_rdata, err_event, rx_restart, dm_wdata, cm_low_q, cm_high_q;
  logic [15:0][1:0] stream_rate;
  logic [11:0] dm_addr, cm_rd_addr;
  logic [15:0][7:0] start_channel;
  logic [15:0][8:0] rx_length;
  logic [15:0][15:0] error_count;
  logic [1:0] mem_select;
  int num_errors, checks_done, i;
  logic [13:0] a;

  berrx_bus_if bus();
  berrx_dev u_berrx_dev (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .err_event(err_event),
    .rx_restart(rx_restart), .stream_rate(stream_rate), .dm_wr(dm_wr), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .cm_rd_addr(cm_rd_addr), .start_channel(start_channel),
    .rx_length(rx_length), .error_count(error_count), .mem_select(mem_select),
    .cm_low_q(cm_low_q), .cm_high_q(cm_high_q));
  berrx_host u_berrx_host (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
  berrx_checker u_berrx_checker (.ref_clk(ref_clk), .rstn(rstn), .addr(bus.addr),
    .wdata(bus.wdata), .wr_strobe(bus.wr_strobe), .rd_strobe(bus.rd_strobe), .rdata(bus.rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // gap edge after each strobe so the next call never re-assigns it in one step
  task automatic cpu_w(input logic [2:0] ad, input logic [15:0] d);
    cpu_addr <= ad;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : cpu_w

  task automatic cpu_r(input logic [2:0] ad, output logic [15:0] q);
    cpu_addr <= ad;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    #1 q = cpu_rdata;
    @(posedge ref_clk);
  endtask : cpu_r

  task automatic bus_op(input logic [13:0] ad, input logic [15:0] d, input logic [1:0] cmd,
      output logic [15:0] q);
    int n;
    cpu_w(`BERRX_HOST_ADDR, {2'b00, ad});
    cpu_w(`BERRX_HOST_WDATA, d);
    cpu_w(`BERRX_HOST_CMD, {14'h0000, cmd});
    n = 0;
    do begin
      cpu_r(`BERRX_HOST_STATUS, q);
      n++;
    end while (q[1] !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("BAD t=%0t status=%h exp=%h", $time, q, 16'h0002);
    end
    cpu_r(`BERRX_HOST_RDATA, q);
  endtask : bus_op

  task automatic wr(input logic [13:0] ad, input logic [15:0] d);
    logic [15:0] q;
    bus_op(ad, d, 2'h1, q);
  endtask : wr

  task automatic rd(input logic [13:0] ad, input logic [15:0] e);
    logic [15:0] q;
    bus_op(ad, 16'h0000, 2'h2, q);
    chk(q, e);
  endtask : rd

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    {cpu_wr, cpu_rd, dm_wr, cpu_addr, cpu_wdata, err_event, rx_restart} = '0;
    {dm_addr, dm_wdata, cm_rd_addr} = '0;
    // streams 0..3 at the four rates, lowest first
    stream_rate = 32'h0000_00E4;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(14'h0300, 16'h0000);
    rd(14'h032F, 16'h0000);
    rd(14'h036F, 16'h0000);
    rd(14'h0310, 16'h0000);
    $display("test reset values done");
    for (i = 0; i < 16; i++) begin
      wr(14'(14'h0300 + i), 16'(16'hFF00 + i * 17));
      rd(14'(14'h0300 + i), 16'(i * 17));
      chk({8'h00, start_channel[i]}, 16'(i * 17));
      wr(14'(14'h0320 + i), 16'(16'hFFFF - i));
      rd(14'(14'h0320 + i), 16'(16'h01FF - i));
      chk({7'h00, rx_length[i]}, 16'(16'h01FF - i));
      wr(14'(14'h0360 + i), 16'h1234);
      rd(14'(14'h0360 + i), 16'h0000);
    end
    $display("test register file done");
    err_event <= 16'h0004;
    repeat (3) @(posedge ref_clk);
    err_event <= 16'h0000;
    @(posedge ref_clk);
    rd(14'h0362, 16'h0003);
    err_event <= 16'h0004;
    repeat (65540) @(posedge ref_clk);
    err_event <= 16'h0000;
    @(posedge ref_clk);
    rd(14'h0362, 16'hFFFF);
    chk(error_count[2], 16'hFFFF);
    rx_restart <= 16'h0004;
    @(posedge ref_clk);
    rx_restart <= 16'h0000;
    @(posedge ref_clk);
    rd(14'h0362, 16'h0000);
    err_event <= 16'h0004;
    rx_restart <= 16'h0004;
    @(posedge ref_clk);
    err_event <= 16'h0000;
    rx_restart <= 16'h0000;
    @(posedge ref_clk);
    chk(error_count[2], 16'h0001);
    $display("test error counter done");
    wr(14'h0000, 16'h0001);
    chk({14'h0000, mem_select}, 16'h0001);
    for (i = 0; i < 4; i++) begin
      a = 14'(14'h2000 + i * 256 + (32 << i) - 1);
      wr(a, 16'(16'hA000 + i));
      rd(a, 16'(16'hA000 + i));
      if (i < 3) begin
        wr(14'(a + 1), 16'h5555);
        rd(14'(a + 1), 16'h0000);
      end
    end
    wr(14'h0000, 16'h0002);
    wr(14'h2307, 16'hBEEF);
    rd(14'h2307, 16'hBEEF);
    rd(14'h3007, 16'h0000);
    rd(14'h0305, 16'h0055);
    cm_rd_addr <= 12'h307;
    repeat (2) @(posedge ref_clk);
    chk(cm_high_q, 16'hBEEF);
    cm_rd_addr <= 12'h3FF;
    repeat (2) @(posedge ref_clk);
    chk(cm_low_q, 16'hA003);
    wr(14'h0000, 16'h0003);
    rd(14'h0000, 16'h0003);
    rd(14'h2307, 16'h0000);
    wr(14'h0000, 16'h0000);
    dm_addr <= 12'h10A;
    dm_wdata <= 16'hC0DE;
    dm_wr <= 1'b1;
    @(posedge ref_clk);
    dm_wr <= 1'b0;
    wr(14'h210A, 16'h1111);
    rd(14'h210A, 16'hC0DE);
    $display("test memory space done");
    tally_and_finish();
  end
endmodule : ber_receiver_regs_memory_map_tb

/* test/berrx_checker.sv */
`timescale 1ns/10ps
module berrx_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [15:0] rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // last bus write; start and length reads of the same word must echo its stored bits
  logic [13:0] last_a_reg;
  logic [15:0] last_d_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      last_a_reg <= 14'h3FFF;
      last_d_reg <= 16'h0000;
    end else if (wr_strobe) begin
      last_a_reg <= addr;
      last_d_reg <= wdata;
    end
  end
  wire logic same_a = rd_strobe && addr == last_a_reg;

  property p_rdata_idle;
    rdata != 16'h0000 |-> $past(rd_strobe);
  endproperty
  property p_start_rsv;
    rd_strobe && addr[13:4] == 10'h030 |=> rdata[15:8] == 8'h00;
  endproperty
  property p_len_rsv;
    rd_strobe && addr[13:4] == 10'h032 |=> rdata[15:9] == 7'h00;
  endproperty
  property p_unmapped;
    rd_strobe && addr[13:4] == 10'h031 |=> rdata == 16'h0000;
  endproperty
  property p_stream_range;
    rd_strobe && addr[13] && addr[12] |=> rdata == 16'h0000;
  endproperty
  property p_start_rw;
    same_a && addr[13:4] == 10'h030 |=> rdata == (last_d_reg & 16'h00FF);
  endproperty
  property p_len_rw;
    same_a && addr[13:4] == 10'h032 |=> rdata == (last_d_reg & 16'h01FF);
  endproperty
  property p_excl;
    !(wr_strobe && rd_strobe);
  endproperty
  property p_pulse;
    rd_strobe |=> !rd_strobe;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle)
    else $error("rdata outside read slot");
  a_start_rsv: assert property (p_start_rsv)
    else $error("start upper byte not zero");
  a_len_rsv: assert property (p_len_rsv)
    else $error("length upper bits not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_stream_range: assert property (p_stream_range)
    else $error("stream above 15 read not zero");
  a_start_rw: assert property (p_start_rw)
    else $error("start readback wrong");
  a_len_rw: assert property (p_len_rw)
    else $error("length readback wrong");
  a_excl: assert property (p_excl)
    else $error("both strobes high");
  a_pulse: assert property (p_pulse)
    else $error("read strobe too long");

  c_start_rw: cover property (same_a && addr[13:4] == 10'h030);
  c_mem_rd: cover property (rd_strobe && addr[13]);
  c_err_rd: cover property (rd_strobe && addr[13:4] == 10'h036);
endmodule : berrx_checker
